//--- rtl/mor_regs.sv
// Operational register page: status, RAM select, ports, serial shifter
// and secondary timer, with the shifter's link-clock logic.
// Assumes the core drives bus_i and evt_i on clk_i, and that software
// leaves the serial settings alone while a byte is shifting.
`default_nettype none
`include "mor_params.svh"

module mor_link (
    input wire logic sck_i,
    input wire logic rst_b_i,
    input wire logic ces_i,
    input wire logic en_i,
    input wire logic od_i,
    input wire logic sdi_i,
    input wire logic [7:0] tx_i,
    output logic [7:0] rx_o,
    output logic tgl_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    mor_pkg::mor_link_s q;
    mor_pkg::mor_link_s n;
    logic sdo_r;
    logic sdo_oe_r;
    wire logic lclk;

    // Turning the pin clock round puts sampling always on the falling
    // edge here; edge select must not change while the clock runs.
    assign lclk = sck_i ^ ces_i;

    always_comb
    begin
        n = q;
        if (en_i)
        begin
            n.sh = {q.sh[6:0], sdi_i};
            n.cnt = q.cnt + 3'h1;
            if (q.cnt == 3'h7)
            begin
                n.hold = {q.sh[6:0], sdi_i};
                n.tgl = ~q.tgl;
            end
        end
    end

    always_ff @(negedge lclk or negedge rst_b_i)
    begin
        if (!rst_b_i)
            q <= '0;
        else
            q <= n;
    end

    // The transmit byte is held steady by shift enable, so it is safe
    // to read here without a synchroniser.
    always_ff @(posedge lclk or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end
        else
        begin
            sdo_r <= tx_i[3'h7 - q.cnt];
            sdo_oe_r <= en_i & (~od_i | ~tx_i[3'h7 - q.cnt]);
        end
    end

    assign rx_o = q.hold;
    assign tgl_o = q.tgl;
    assign sdo_o = sdo_r;
    assign sdo_oe_o = sdo_oe_r;
endmodule

module mor_regs (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire mor_pkg::mor_bus_s bus_i,
    input wire mor_pkg::mor_evt_s evt_i,
    input wire logic [7:0] pc_low_i,
    input wire logic [39:0] port_pin_i,
    input wire logic slave_i,
    input wire logic secondary_timer_count_mode_i,
    input wire logic sck_i,
    input wire logic sdi_i,
    output logic [7:0] rdata_o,
    output logic [1:0] pc_page_o,
    output logic [1:0] bank_o,
    output logic [39:0] port_o,
    output logic [3:0] isr_o,
    output logic sck_o,
    output logic sck_oe_o,
    output logic sdo_o,
    output logic sdo_oe_o
);
    mor_pkg::mor_core_s q;
    mor_pkg::mor_core_s n;
    logic [5:0] ea;
    logic [7:0] rv;
    logic [7:0] w;
    logic [7:0] half;
    logic [7:0] link_rx;
    logic link_tgl;
    logic done;
    logic jump;
    logic mst;
    logic rx_rd;

    mor_link u_link (
        .sck_i(sck_i),
        .rst_b_i(rst_b_i),
        .ces_i(q.serial_control[`MOR_SC_CES]),
        // Shift enable gates the bit counter as well, so the pin settling
        // to a new idle level between bytes is never counted as a bit.
        .en_i(q.serial_control[`MOR_SC_SERIAL_PORT_ENABLE] & q.serial_control[`MOR_SC_SSE]),
        .od_i(q.serial_status[`MOR_SS_OD3]),
        .sdi_i(sdi_i),
        .tx_i(q.txb),
        .rx_o(link_rx),
        .tgl_o(link_tgl),
        .sdo_o(sdo_o),
        .sdo_oe_o(sdo_oe_o)
    );

    always_comb
    begin
        n = q;
        w = bus_i.wdata;
        n.pin1 = port_pin_i;
        n.pin2 = q.pin1;
        n.dsy = {q.dsy[1:0], link_tgl};
        // The held byte stays put for a whole byte time, far longer
        // than the toggle takes to cross.
        done = q.dsy[2] ^ q.dsy[1];
        ea = (bus_i.addr == `MOR_A_IND) ? q.ram_bank_select[5:0] : bus_i.addr;
        rx_rd = bus_i.re & (ea == `MOR_A_RXB);
        jump = evt_i.jump | (bus_i.we & (ea == `MOR_A_PCL));
        mst = q.serial_control[`MOR_SC_SERIAL_PORT_ENABLE] & ~slave_i;
        half = 8'h01 << q.serial_control[2:0];

        rv = 8'h00;
        case (ea)
        `MOR_A_TCC: rv = q.tcc;
        `MOR_A_PCL: rv = pc_low_i;
        `MOR_A_STAT: rv = q.stat;
        `MOR_A_RSR: rv = q.ram_bank_select;
        `MOR_A_P5: rv = q.pin2[0];
        `MOR_A_P6: rv = q.pin2[1];
        `MOR_A_P7: rv = {q.pin2[2][5:4], q.pin2[2][5:4], q.pin2[2][3:0]};
        `MOR_A_P8: rv = q.pin2[3];
        `MOR_A_P9: rv = q.pin2[4] & `MOR_P9_MASK;
        `MOR_A_RXB: rv = q.rxb;
        `MOR_A_TXB: rv = q.txb;
        `MOR_A_SERIAL_STATUS: rv = {3'h0, q.serial_status};
        `MOR_A_SERIAL_CONTROL: rv = q.serial_control;
        `MOR_A_SECONDARY_TIMER_COUNT: rv = q.secondary_timer_count;
        `MOR_A_PWP: rv = q.pulse_width_preset;
        `MOR_A_ISR: rv = {4'h0, q.isr};
        default: rv = 8'h00;
        endcase
        if (bus_i.re)
            n.rdata = rv;

        n.tcc = q.tcc + 8'h01;
        n.secondary_timer_count = (q.secondary_timer_count == q.pulse_width_preset) ? 8'h00 : q.secondary_timer_count + 8'h01;
        if (rx_rd)
            n.serial_status[`MOR_SS_RBF] = 1'b0;
        if (done)
            n.serial_control[`MOR_SC_SSE] = 1'b0;

        if (bus_i.we)
        begin
            case (ea)
            `MOR_A_TCC: n.tcc = w;
            `MOR_A_STAT: n.stat = {w[7], 1'b0, w[5], q.stat[4:3], w[2:0]};
            `MOR_A_RSR: n.ram_bank_select = w;
            `MOR_A_P5: n.port[0] = w;
            `MOR_A_P6: n.port[1] = w;
            `MOR_A_P7: n.port[2] = w;
            `MOR_A_P8: n.port[3] = w;
            `MOR_A_P9: n.port[4] = w & `MOR_P9_MASK;
            `MOR_A_TXB:
            begin
                if (!q.serial_control[`MOR_SC_SSE])
                    n.txb = w;
            end
            `MOR_A_SERIAL_STATUS: n.serial_status = w[4:0];
            `MOR_A_SERIAL_CONTROL: n.serial_control = w;
            `MOR_A_SECONDARY_TIMER_COUNT: n.secondary_timer_count = w;
            `MOR_A_PWP: n.pulse_width_preset = w;
            `MOR_A_ISR: n.isr = q.isr & w[3:0];
            default: ;
            endcase
        end

        if (jump)
            n.page = q.stat[6:5];
        else if (evt_i.ret)
            n.page = evt_i.ret_page;
        if (evt_i.wdt_to)
            n.stat[`MOR_ST_T] = 1'b0;
        if (evt_i.sleep)
        begin
            n.stat[`MOR_ST_T] = 1'b1;
            n.stat[`MOR_ST_P] = 1'b0;
        end
        if (evt_i.watchdog_clear_instruction)
        begin
            n.stat[`MOR_ST_T] = 1'b1;
            n.stat[`MOR_ST_P] = 1'b1;
        end
        if (evt_i.flag_we)
            n.stat[2:0] = evt_i.flags;

        // Hardware sets come last so that a clear in the same cycle loses.
        if (q.tcc == 8'hFF)
            n.isr[`MOR_IS_TC] = 1'b1;
        if (q.secondary_timer_count == q.pulse_width_preset)
            n.isr[`MOR_IS_TM1] = 1'b1;
        if (done)
        begin
            n.rxb = link_rx;
            if (slave_i & q.serial_status[`MOR_SS_RBF] & ~rx_rd)
                n.serial_control[`MOR_SC_SRO] = 1'b1;
            n.serial_status[`MOR_SS_RBF] = 1'b1;
            n.serial_status[`MOR_SS_RX_FULL_IRQ_FLAG] = 1'b1;
            if (secondary_timer_count_mode_i)
                n.serial_status[`MOR_SS_TM1] = 1'b1;
            n.isr[`MOR_IS_SPI] = 1'b1;
        end

        case (q.sst)
        mor_pkg::MOR_IDLE:
        begin
            n.sck = q.serial_control[`MOR_SC_CES];
            n.div = 8'h00;
            n.edges = 5'h00;
            if (q.serial_control[`MOR_SC_SSE])
                n.sst = mor_pkg::MOR_RUN;
        end
        mor_pkg::MOR_RUN:
        begin
            n.div = q.div + 8'h01;
            if (q.div == half - 8'h01)
            begin
                n.div = 8'h00;
                n.sck = ~q.sck;
                n.edges = q.edges + 5'h01;
                if (q.edges == `MOR_EDGES - 5'h01)
                    n.sst = mor_pkg::MOR_WAIT;
            end
        end
        mor_pkg::MOR_WAIT:
        begin
            if (!q.serial_control[`MOR_SC_SSE])
                n.sst = mor_pkg::MOR_IDLE;
        end
        default: n.sst = mor_pkg::MOR_IDLE;
        endcase
        if (!mst)
            n.sst = mor_pkg::MOR_IDLE;
        n.sck_oe = mst & (~q.serial_status[`MOR_SS_OD4] | ~n.sck);
    end

    always_ff @(posedge clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            q <= '0;
            q.stat <= `MOR_ST_RST;
            q.page <= `MOR_PAGE_RST;
            q.sst <= mor_pkg::MOR_IDLE;
        end
        else
            q <= n;
    end

    assign rdata_o = q.rdata;
    assign pc_page_o = q.page;
    assign bank_o = q.ram_bank_select[7:6];
    assign port_o = q.port;
    assign isr_o = q.isr;
    assign sck_o = q.sck;
    assign sck_oe_o = q.sck_oe;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!rst_b_i);

    chk_page_load: assert property (jump |=> q.page == $past(q.stat[6:5]))
        else $error("Page not loaded on jump.");
    chk_ret_page: assert property (evt_i.ret && !jump && !bus_i.we
        |=> q.stat[6:5] == $past(q.stat[6:5]) && q.page == $past(evt_i.ret_page))
        else $error("Return disturbed page select.");
    chk_ps_high: assert property ((bus_i.we && ea == `MOR_A_STAT) || jump
        |=> !q.stat[6] && (!$past(jump) || !pc_page_o[1]))
        else $error("Upper page bit set.");
    chk_sleep_flags: assert property (evt_i.sleep && !evt_i.watchdog_clear_instruction
        |=> q.stat[4] && !q.stat[3])
        else $error("Sleep flags wrong.");
    chk_watchdog_clear_instruction_flags: assert property (evt_i.watchdog_clear_instruction |=> q.stat[4] && q.stat[3])
        else $error("Watchdog clear flags wrong.");
    chk_wdt_timeout: assert property (evt_i.wdt_to && !evt_i.sleep
        && !evt_i.watchdog_clear_instruction |=> !q.stat[4])
        else $error("Timeout did not clear flag.");
    chk_zero_flag: assert property (evt_i.flag_we
        |=> q.stat[2:0] == $past(evt_i.flags))
        else $error("ALU flags not taken.");
    chk_indirect_read: assert property (bus_i.re && bus_i.addr == `MOR_A_IND
        && q.ram_bank_select[5:0] == `MOR_A_PWP |=> rdata_o == $past(q.pulse_width_preset))
        else $error("Indirect read wrong.");
    chk_port9_msb: assert property (bus_i.re && ea == `MOR_A_P9
        |=> rdata_o[7:6] == 2'h0)
        else $error("Port 9 top bits not zero.");
    chk_done_flags: assert property (done && !(bus_i.we && ea == `MOR_A_SERIAL_CONTROL)
        |=> q.serial_status[`MOR_SS_RBF]
        && q.serial_status[`MOR_SS_RX_FULL_IRQ_FLAG] && q.isr[`MOR_IS_SPI]
        && !q.serial_control[`MOR_SC_SSE] && q.rxb == $past(link_rx))
        else $error("Transfer end flags wrong.");
    chk_secondary_timer_count_wrap: assert property (q.secondary_timer_count == q.pulse_width_preset && !bus_i.we
        |=> q.secondary_timer_count == 8'h00 ##1 (q.secondary_timer_count == 8'h01 || q.pulse_width_preset == 8'h00
        || $past(bus_i.we)))
        else $error("Timer did not wrap.");
    chk_sck_od: assert property (sck_oe_o && $past(q.serial_status[`MOR_SS_OD4])
        |-> !sck_o)
        else $error("Open drain drove high.");
    chk_run_sse: assert property (q.sst == mor_pkg::MOR_RUN
        |-> q.serial_control[`MOR_SC_SSE])
        else $error("Clock ran without shift enable.");

    cov_done: cover property (done);
    cov_master: cover property (q.sst == mor_pkg::MOR_WAIT
        ##1 q.sst == mor_pkg::MOR_IDLE);
    cov_overflow: cover property (!q.serial_control[`MOR_SC_SRO]
        ##1 q.serial_control[`MOR_SC_SRO]);
endmodule
`default_nettype wire

//--- rtl/mor_params.svh
// Constants of the operational register page: offsets, bit positions,
// reset values and transfer counts. Definitions only, no logic.
// Summary of operation
// - Jump, call or program counter write loads page select into PC bits 10-11.
// - Returns take the page from the stack and never alter page select.
// - Upper page select bit reads zero and ignores writes.
// - Page codes 0 to 3 select 1K-word pages 000, 400, 800, C00.
// - Timeout flag set by sleep, watchdog clear or power up; cleared by timeout.
// - Power-down flag set by power on or watchdog clear; cleared by sleep.
// - Zero, nibble carry and carry flags sit in status bits 2, 1, 0.
// - RAM select bits 7-6 choose one of four data banks.
// - RAM select bits 5-0 give the indirect register address.
// - RAM select is a plain 8-bit register when not used indirectly.
// - Port 7 bits 4 and 6 share DATA; bits 5 and 7 share CLK.
// - Port 9 holds six bits; its top two bits read zero.
// - Receive buffer holds the whole byte captured at transfer end.
// - Transmit buffer holds the software byte until it is shifted out.
// - In timer mode serial status bit 4 sets when reception completes.
// - Serial status bits 3 and 2 make SDO and SCK open drain.
// - A received byte sets buffer-full and buffer-full interrupt flags.
// - Edge select 0 shifts out rising, in falling, idles low; 1 swaps.
// - Control bit 6 enables the serial port.
// - Slave mode sets read overflow when a byte lands on an unread one.
// - Software sets shift enable to start; hardware clears it per byte.
// - Secondary timer counts up to the preset value, then returns to zero.
// - Serial interrupt flag sets on transfer end; software alone clears it.
`ifndef MOR_PARAMS_SVH
`define MOR_PARAMS_SVH
`define MOR_A_IND 6'h00
`define MOR_A_TCC 6'h01
`define MOR_A_PCL 6'h02
`define MOR_A_STAT 6'h03
`define MOR_A_RSR 6'h04
`define MOR_A_P5 6'h05
`define MOR_A_P6 6'h06
`define MOR_A_P7 6'h07
`define MOR_A_P8 6'h08
`define MOR_A_P9 6'h09
`define MOR_A_RXB 6'h0A
`define MOR_A_TXB 6'h0B
`define MOR_A_SERIAL_STATUS 6'h0C
`define MOR_A_SERIAL_CONTROL 6'h0D
`define MOR_A_SECONDARY_TIMER_COUNT 6'h0E
`define MOR_A_PWP 6'h0F
`define MOR_A_ISR 6'h3F
`define MOR_ST_T 4
`define MOR_ST_P 3
`define MOR_ST_RST 8'h18
`define MOR_PAGE_RST 2'h3
`define MOR_SS_TM1 4
`define MOR_SS_OD3 3
`define MOR_SS_OD4 2
`define MOR_SS_RX_FULL_IRQ_FLAG 1
`define MOR_SS_RBF 0
`define MOR_SC_CES 7
`define MOR_SC_SERIAL_PORT_ENABLE 6
`define MOR_SC_SRO 5
`define MOR_SC_SSE 4
`define MOR_IS_TM1 3
`define MOR_IS_SPI 2
`define MOR_IS_TC 0
`define MOR_P9_MASK 8'h3F
`define MOR_EDGES 5'h10
`endif

//--- rtl/mor_pkg.sv
// Types of the operational register page.
// Assumes nothing of its surroundings.
`default_nettype none
package mor_pkg;
    typedef enum logic [2:0] {
        MOR_IDLE = 3'h1,
        MOR_RUN = 3'h2,
        MOR_WAIT = 3'h4
    } mor_sck_e;
    typedef struct packed {
        logic [5:0] addr;
        logic we;
        logic re;
        logic [7:0] wdata;
    } mor_bus_s;
    typedef struct packed {
        logic jump;
        logic ret;
        logic [1:0] ret_page;
        logic sleep;
        logic watchdog_clear_instruction;
        logic wdt_to;
        logic flag_we;
        logic [2:0] flags;
    } mor_evt_s;
    typedef struct packed {
        logic [4:0][7:0] pin1;
        logic [4:0][7:0] pin2;
        logic [2:0] dsy;
        logic [7:0] tcc;
        logic [7:0] ram_bank_select;
        logic [7:0] stat;
        logic [7:0] rxb;
        logic [7:0] txb;
        logic [7:0] serial_control;
        logic [7:0] secondary_timer_count;
        logic [7:0] pulse_width_preset;
        logic [7:0] rdata;
        logic [7:0] div;
        logic [4:0] serial_status;
        logic [3:0] isr;
        logic [1:0] page;
        logic [4:0][7:0] port;
        logic [4:0] edges;
        mor_sck_e sst;
        logic sck;
        logic sck_oe;
    } mor_core_s;
    typedef struct packed {
        logic [2:0] cnt;
        logic [7:0] sh;
        logic [7:0] hold;
        logic tgl;
    } mor_link_s;
endpackage
`default_nettype wire

//--- sim/mor_peer.sv
// Behavioural serial peer: loads a byte on go_i, clocks it when asked.
// Assumes the bench feeds it the SCK and SDO pin levels, pulled up.
`default_nettype none
module mor_peer (
    input wire logic ces_i,
    input wire logic drive_i,
    input wire logic go_i,
    input wire logic sck_i,
    input wire logic sdo_i,
    input wire logic [7:0] tx_i,
    output logic sck_o,
    output logic sdi_o,
    output logic [7:0] rx_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] sh;
    wire out_edge = sck_i ^ ces_i;
    initial
    begin
        sck_o = 1'b1;
        sdi_o = 1'b1;
        rx_o = 8'h00;
        sh = 8'h00;
    end
    // The clock only runs inside a frame and rests on the pull-up level,
    // so slave frames must use the high idle level.
    always @(posedge go_i)
    begin
        sh = tx_i;
        if (drive_i)
        begin
            #7;
            repeat (16)
            begin
                #32;
                sck_o = ~sck_o;
            end
        end
    end
    // Sent bits are replaced by their inverse so a stale line cannot match.
    always @(posedge out_edge)
    begin
        sdi_o = sh[7];
        sh = {sh[6:0], ~sh[7]};
    end
    always @(negedge out_edge)
        rx_o = {rx_o[6:0], sdo_i};
endmodule
`default_nettype wire

//--- sim/test_mcu_operational_registers.sv
// Self-checking bench of the operational register page and serial port.
// Assumes mor_pkg is compiled first and the peer model sits on the pins.
`default_nettype none
module test_mcu_operational_registers;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_i, rst_b_i, slave_i, secondary_timer_count_mode_i, go, drive, clock_edge_select, sdi;
    logic sck_o, sck_oe_o, sdo_o, sdo_oe_o, peer_sck;
    mor_pkg::mor_bus_s bus_i;
    mor_pkg::mor_evt_s evt_i;
    logic [7:0] pc_low_i, rdata_o, ptx, rd, w, peer_rx;
    logic [39:0] port_pin_i, port_o;
    logic [1:0] pc_page_o, bank_o;
    logic [3:0] isr_o;
    int errors = 0;
    int n_checks = 0;
    int cyc = 0;
    wire sck_pin = sck_oe_o ? sck_o : peer_sck;
    wire sdo_pin = sdo_oe_o ? sdo_o : 1'b1;
    mor_regs dut (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus_i(bus_i),
        .evt_i(evt_i), .pc_low_i(pc_low_i), .port_pin_i(port_pin_i),
        .slave_i(slave_i), .secondary_timer_count_mode_i(secondary_timer_count_mode_i), .sck_i(sck_pin),
        .sdi_i(sdi), .rdata_o(rdata_o), .pc_page_o(pc_page_o),
        .bank_o(bank_o), .port_o(port_o), .isr_o(isr_o), .sck_o(sck_o),
        .sck_oe_o(sck_oe_o), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o));
    mor_peer peer (.ces_i(clock_edge_select), .drive_i(drive), .go_i(go),
        .sck_i(sck_pin), .sdo_i(sdo_pin), .tx_i(ptx), .sck_o(peer_sck),
        .sdi_o(sdi), .rx_o(peer_rx));
    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            errors++;
            final_report();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("[ERR] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk_i) bus_i <= '{a, 1'b1, 1'b0, d};
        @(posedge clk_i) bus_i.we <= 1'b0;
    endtask
    task automatic rdr(input logic [5:0] a);
        @(posedge clk_i) bus_i <= '{a, 1'b0, 1'b1, 8'h00};
        @(posedge clk_i) bus_i.re <= 1'b0;
        @(posedge clk_i) #1 rd = rdata_o;
    endtask
    task automatic ev(input logic [10:0] e);
        @(posedge clk_i) evt_i <= mor_pkg::mor_evt_s'(e);
        @(posedge clk_i) evt_i <= '0;
        @(posedge clk_i) #1;
    endtask
    function automatic logic [7:0] p7_exp(input logic [39:0] p);
        return {p[21], p[20], p[21], p[20], p[19:16]};
    endfunction
    // Software leaves the settings alone while a byte shifts.
    task automatic xfer(input logic c, input logic [2:0] b, input logic sl);
        logic [7:0] t;
        int k;
        t = 8'($urandom);
        ptx = 8'($urandom);
        clock_edge_select = c;
        drive = sl;
        wr(6'h0D, {c, 7'h40});
        repeat (4) @(posedge clk_i);
        wr(6'h0B, t);
        if (sl)
            wr(6'h0D, {c, 4'hA, b});
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        if (!sl)
            wr(6'h0D, {c, 4'hA, b});
        k = 0;
        rd = 8'h10;
        while (rd[4] !== 1'b0 && k < 300)
        begin
            rdr(6'h0D);
            k++;
        end
        chk(8'(rd[4]), 8'h00);
        chk(peer_rx, t);
        rdr(6'h0C);
        chk(rd & 8'h13, {3'h0, secondary_timer_count_mode_i, 4'h3});
        if (!sl)
        begin
            rdr(6'h0A);
            chk(rd, ptx);
            chk(8'(isr_o) & 8'h04, 8'h04);
            wr(6'h3F, 8'h00);
            @(posedge clk_i) #1;
            chk(8'(isr_o) & 8'h04, 8'h00);
        end
        // A slave byte is left unread, so the next one can overrun it.
        wr(6'h0C, {7'h00, sl});
    endtask
    initial
    begin
        {rst_b_i, slave_i, secondary_timer_count_mode_i, go, drive, clock_edge_select} = '0;
        bus_i = '0;
        evt_i = '0;
        pc_low_i = 8'h5A;
        port_pin_i = '0;
        ptx = 8'h00;
        void'($urandom(56644));
        repeat (8) @(posedge clk_i);
        rst_b_i <= 1'b1;
        rdr(6'h03);
        chk(rd, 8'h18);
        rdr(6'h02);
        chk(rd, 8'h5A);
        wr(6'h03, 8'hFF);
        rdr(6'h03);
        chk(rd, 8'hBF);
        $display("test status access done");
        for (int i = 0; i < 6; i++)
        begin
            w = 8'($urandom);
            wr(6'h03, w);
            ev(11'h400);
            chk(8'(pc_page_o), {7'h0, w[5]});
            ev({2'b01, 2'(i), 7'h00});
            chk(8'(pc_page_o), 8'(i % 4));
            rdr(6'h03);
            chk(8'(rd[6:5]), {7'h0, w[5]});
        end
        ev(11'h040);
        rdr(6'h03);
        chk(8'(rd[4:3]), 8'h02);
        ev(11'h010);
        rdr(6'h03);
        chk(8'(rd[4:3]), 8'h00);
        ev(11'h020);
        rdr(6'h03);
        chk(8'(rd[4:3]), 8'h03);
        for (int f = 0; f < 8; f++)
        begin
            ev(11'h008 | 11'(f));
            rdr(6'h03);
            chk(8'(rd[2:0]), 8'(f));
        end
        $display("test page and events done");
        repeat (4)
        begin
            w = 8'($urandom);
            wr(6'h04, w);
            rdr(6'h04);
            chk(rd, w);
            chk(8'(bank_o), 8'(w[7:6]));
        end
        wr(6'h04, 8'h0F);
        w = 8'($urandom);
        wr(6'h00, w);
        rdr(6'h0F);
        chk(rd, w);
        wr(6'h0F, ~w);
        rdr(6'h00);
        chk(rd, ~w);
        for (int a = 5; a < 10; a++)
        begin
            w = 8'($urandom);
            wr(6'(a), w);
            #1;
            chk(port_o[(a-5)*8 +: 8], (a == 9) ? (w & 8'h3F) : w);
        end
        @(posedge clk_i) port_pin_i <= {8'($urandom), $urandom};
        repeat (4) @(posedge clk_i);
        rdr(6'h07);
        chk(rd, p7_exp(port_pin_i));
        rdr(6'h09);
        chk(rd, {2'b00, port_pin_i[37:32]});
        wr(6'h0F, 8'h05);
        wr(6'h0E, 8'h00);
        repeat (12)
        begin
            rdr(6'h0E);
            chk((rd > 8'h05) ? 8'hFF : 8'h00, 8'h00);
        end
        $display("test registers and ports done");
        for (int i = 0; i < 6; i++)
        begin
            @(posedge clk_i) secondary_timer_count_mode_i <= 1'($urandom);
            xfer(1'(i), 3'(i % 3), 1'b0);
        end
        wr(6'h0D, 8'hC0);
        wr(6'h0C, 8'h04);
        repeat (4) @(posedge clk_i);
        chk(8'(sck_oe_o), 8'h00);
        wr(6'h0C, 8'h00);
        repeat (4) @(posedge clk_i);
        chk(8'(sck_oe_o), 8'h01);
        $display("test master transfers done");
        @(posedge clk_i) slave_i <= 1'b1;
        xfer(1'b1, 3'h0, 1'b1);
        rdr(6'h0D);
        chk(8'(rd[5]), 8'h00);
        xfer(1'b1, 3'h0, 1'b1);
        rdr(6'h0D);
        chk(8'(rd[5]), 8'h01);
        rdr(6'h0A);
        wr(6'h0D, 8'h90);
        @(posedge clk_i) go <= 1'b1;
        @(posedge clk_i) go <= 1'b0;
        repeat (20) @(posedge clk_i);
        rdr(6'h0C);
        chk(8'(rd[0]), 8'h00);
        wr(6'h0D, 8'h00);
        $display("test slave transfers done");
        final_report();
    end
endmodule
`default_nettype wire
